// file: ssp_regs.vh
// constants for the synchronous serial port block
`ifndef SSP_REGS_VH
`define SSP_REGS_VH
`define SSP_MODE_SLAVE_SEL   4'h4
`define SSP_MODE_SLAVE_NOSEL 4'h5
`define SSP_MODE_I2C_SL7     4'h6
`define SSP_MODE_I2C_SL10    4'h7
`define SSP_MODE_I2C_MASTER  4'h8
`define SSP_MASK_HI          5
`define SSP_MASK_LO          1
`define SSP_RELOAD_W         7
`define SSP_BYTE_BITS        4'h8
`define SSP_RELOAD_RST       7'h00
`endif

// file: ssp_baud.v
// baud counter for the master bit clock
`timescale 1ns/1ns
module ssp_baud #(
  parameter W = 7
) (
  input  wire         i_clock,
  input  wire         i_arst_n,
  input  wire         i_phase_en,
  input  wire         i_load,
  input  wire         i_auto,
  input  wire [W-1:0] i_reload,
  output reg          o_rollover,
  output reg          o_running
);
  reg [W-1:0] baud_counter_r;
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      baud_counter_r <= {W{1'b0}};
      o_rollover     <= 1'b0;
      o_running      <= 1'b0;
    end else begin
      o_rollover <= 1'b0;
      if (i_load) begin
        baud_counter_r <= i_reload;
        o_running      <= 1'b1;
      end else if (o_running && i_phase_en) begin
        if (baud_counter_r != {W{1'b0}}) begin
          baud_counter_r <= baud_counter_r - {{(W-1){1'b0}}, 1'b1};
        end else begin
          o_rollover <= 1'b1;
          if (i_auto) begin
            baud_counter_r <= i_reload;
          end else begin
            o_running <= 1'b0;
          end
        end
      end
    end
  end
endmodule

// file: ssp_port.v
// synchronous serial port: spi slave, i2c address match, master bit clock
`timescale 1ns/1ns
`include "ssp_regs.vh"
module ssp_port #(
  parameter NBITS = 8
) (
  input  wire             i_clock,
  input  wire             i_arst_n,
  input  wire             i_port_enable_bit,
  input  wire [3:0]       i_port_mode,
  input  wire             i_clock_polarity_sel,
  input  wire             i_clock_edge_sel,
  input  wire             i_sdo_is_input,
  input  wire             i_sleep,
  input  wire             i_sck,
  input  wire             i_sdi,
  input  wire             i_ss_n,
  input  wire [NBITS-1:0] i_own_address_or_reload,
  input  wire [4:0]       i_address_mask_field,
  input  wire             i_buf_write,
  input  wire [NBITS-1:0] i_buf_wdata,
  input  wire             i_i2c_addr_valid,
  input  wire [NBITS-1:0] i_i2c_addr_byte,
  input  wire             i_i2c_ten_hi_ok,
  input  wire             i_op_done,
  input  wire             i_irq_clear,
  output reg  [NBITS-1:0] o_shift_data_buffer,
  output reg              o_port_irq_flag,
  output reg              o_wake,
  output reg              o_sdo,
  output reg              o_sdo_oe,
  output reg              o_addr_ack,
  output reg              o_scl,
  output reg              o_bit_clock_run
);
  // ****************************************
  // input synchronisers
  // ****************************************
  reg [2:0] sck_s_r;
  reg [2:0] sdi_s_r;
  reg [2:0] ss_s_r;
  reg       sck_lvl_r;
  reg       ss_lvl_r;
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sck_s_r   <= 3'h0;
      sdi_s_r   <= 3'h0;
      ss_s_r    <= 3'h7;
      sck_lvl_r <= 1'b0;
      ss_lvl_r  <= 1'b1;
    end else begin
      sck_s_r <= {sck_s_r[1:0], i_sck};
      sdi_s_r <= {sdi_s_r[1:0], i_sdi};
      ss_s_r  <= {ss_s_r[1:0], i_ss_n};
      if (sck_s_r[1] == sck_s_r[2]) begin
        sck_lvl_r <= sck_s_r[2];
      end
      if (ss_s_r[1] == ss_s_r[2]) begin
        ss_lvl_r <= ss_s_r[2];
      end
    end
  end

  // ****************************************
  // spi slave
  // ****************************************
  wire spi_mode = (i_port_mode == `SSP_MODE_SLAVE_SEL) ||
                  (i_port_mode == `SSP_MODE_SLAVE_NOSEL);
  wire sel_ctrl = (i_port_mode == `SSP_MODE_SLAVE_SEL);
  wire sck_agree = (sck_s_r[1] == sck_s_r[2]);
  wire sck_rise = sck_agree && sck_s_r[2] && !sck_lvl_r;
  wire sck_fall = sck_agree && !sck_s_r[2] && sck_lvl_r;
  // idle level is polarity; first edge leaves idle
  wire lead_edge = i_clock_polarity_sel ? sck_fall : sck_rise;
  wire trail_edge = i_clock_polarity_sel ? sck_rise : sck_fall;
  // edge select on: sample trailing, shift leading
  wire sample_edge = i_clock_edge_sel ? trail_edge : lead_edge;
  wire shift_edge = i_clock_edge_sel ? lead_edge : trail_edge;
  wire selected = !sel_ctrl || !ss_lvl_r;
  // reset on select high or disable
  wire spi_reset = !i_port_enable_bit || (sel_ctrl && ss_lvl_r);

  reg [3:0]       bit_cnt_r;
  reg [NBITS-1:0] shreg_r;
  reg [NBITS-1:0] tx_r;
  reg             tx_pend_r;
  reg             sample_r;
  wire [3:0]      bit_cnt_inc = bit_cnt_r + 4'h1;
  wire            last_bit = (bit_cnt_inc == `SSP_BYTE_BITS);

  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bit_cnt_r <= 4'h0;
      shreg_r   <= {NBITS{1'b0}};
      sample_r  <= 1'b0;
      tx_r      <= {NBITS{1'b0}};
      tx_pend_r <= 1'b0;
    end else begin
      if (i_buf_write) begin
        tx_r      <= i_buf_wdata;
        tx_pend_r <= 1'b1;
      end
      if (spi_reset || !spi_mode) begin
        bit_cnt_r <= 4'h0;
      end else if (selected) begin
        if (sample_edge) begin
          sample_r <= sdi_s_r[2];
        end
        if (sample_edge) begin
          shreg_r <= {shreg_r[NBITS-2:0], sdi_s_r[2]};
          bit_cnt_r <= last_bit ? 4'h0 : bit_cnt_inc;
          if (last_bit) begin
            tx_pend_r <= 1'b0;
          end
        end
      end
    end
  end
  wire spi_done = spi_mode && !spi_reset && selected && sample_edge && last_bit;
  // master operation finished, driven in the bit clock section
  wire mst_done;

  // output bit: msb first, next bit on shift edge
  reg [NBITS-1:0] out_r;
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      out_r <= {NBITS{1'b0}};
    end else if (spi_reset || !spi_mode || (bit_cnt_r == 4'h0 && !shift_edge)) begin
      out_r <= tx_r;
    end else if (selected && shift_edge && bit_cnt_r != 4'h0) begin
      out_r <= {out_r[NBITS-2:0], 1'b0};
    end
  end

  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sdo    <= 1'b0;
      o_sdo_oe <= 1'b0;
    end else begin
      o_sdo <= out_r[NBITS-1];
      // float on select high; not when input
      o_sdo_oe <= spi_mode && i_port_enable_bit && selected && !i_sdo_is_input;
    end
  end

  // ****************************************
  // i2c address match
  // ****************************************
  wire ten_bit = (i_port_mode == `SSP_MODE_I2C_SL10);
  wire i2c_slave = (i_port_mode == `SSP_MODE_I2C_SL7) || ten_bit;
  reg [NBITS-1:0] care;
  integer k;
  always @* begin
    care = {NBITS{1'b1}};
    if (ten_bit) begin
      // mask low pair and bits five to two
      for (k = 2; k <= `SSP_MASK_HI; k = k + 1) begin
        care[k] = !i_address_mask_field[k-1];
      end
      care[1] = !i_address_mask_field[0];
      care[0] = !i_address_mask_field[0];
    end else begin
      // seven-bit mask, bit zero is direction
      for (k = `SSP_MASK_LO; k <= `SSP_MASK_HI; k = k + 1) begin
        care[k] = !i_address_mask_field[k-1];
      end
      care[0] = 1'b0;
    end
  end
  wire addr_eq = (((i_i2c_addr_byte ^ i_own_address_or_reload) & care) == {NBITS{1'b0}});
  // upper two bits checked exactly outside
  wire addr_hit = i2c_slave && i_port_enable_bit && i_i2c_addr_valid && addr_eq &&
                  (!ten_bit || i_i2c_ten_hi_ok);

  // ****************************************
  // buffer and flag
  // ****************************************
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_shift_data_buffer <= {NBITS{1'b0}};
      o_port_irq_flag     <= 1'b0;
      o_wake              <= 1'b0;
      o_addr_ack          <= 1'b0;
    end else begin
      o_addr_ack <= addr_hit;
      if (addr_hit) begin
        o_shift_data_buffer <= i_i2c_addr_byte;
      end else if (spi_done) begin
        o_shift_data_buffer <= {shreg_r[NBITS-2:0], sdi_s_r[2]};
      end
      // set wins over clear
      if (spi_done || addr_hit || mst_done) begin
        o_port_irq_flag <= 1'b1;
      end else if (i_irq_clear) begin
        o_port_irq_flag <= 1'b0;
      end
      o_wake <= i_sleep && spi_done;
    end
  end

  // ****************************************
  // master bit clock
  // ****************************************
  wire master = i_port_enable_bit && (i_port_mode == `SSP_MODE_I2C_MASTER);
  reg  phase_r;
  reg  run_r;
  wire rollover;
  wire brg_running;
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= !phase_r;
    end
  end
  wire tick = phase_r && !i_sleep && master;
  wire brg_load = master && i_buf_write;
  assign mst_done = master && run_r && i_op_done;
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      run_r           <= 1'b0;
      o_scl           <= 1'b1;
      o_bit_clock_run <= 1'b0;
    end else begin
      if (!master || mst_done) begin
        run_r <= 1'b0;
      end else if (brg_load) begin
        run_r <= 1'b1;
      end
      if (!master) begin
        o_scl <= 1'b1;
      end else if (rollover && run_r && !mst_done) begin
        o_scl <= !o_scl;
      end
      // running from the load edge, stopped on the done edge
      o_bit_clock_run <= brg_load || (master && brg_running && run_r && !mst_done);
    end
  end

  ssp_baud #(
    .W(`SSP_RELOAD_W)
  ) u_baud (
    .i_clock    (i_clock),
    .i_arst_n   (i_arst_n),
    .i_phase_en (tick),
    .i_load     (brg_load),
    .i_auto     (run_r && !mst_done),
    .i_reload   (i_own_address_or_reload[`SSP_RELOAD_W-1:0]),
    .o_rollover (rollover),
    .o_running  (brg_running)
  );
endmodule

// file: ssp_port_checker.sv
// concurrent checks on the serial port block's ports
`timescale 1ns/1ns
module ssp_port_checker #(
  parameter NBITS = 8
) (
  input wire             i_clock,
  input wire             i_arst_n,
  input wire [3:0]       i_port_mode,
  input wire             i_sleep,
  input wire             i_ss_n,
  input wire [NBITS-1:0] i_own_address_or_reload,
  input wire [4:0]       i_address_mask_field,
  input wire             i_buf_write,
  input wire             i_i2c_addr_valid,
  input wire [NBITS-1:0] i_i2c_addr_byte,
  input wire             i_i2c_ten_hi_ok,
  input wire             i_op_done,
  input wire             i_irq_clear,
  input wire             o_port_irq_flag,
  input wire             o_sdo_oe,
  input wire             o_addr_ack,
  input wire             o_scl,
  input wire             o_bit_clock_run
);
  // ****************
  // helper logic
  // ****************
  reg       scl_r;
  reg       arm_r;
  reg       hit_r;
  reg [9:0] cnt_r;
  wire [4:0] f = i_address_mask_field;
  wire      ten = (i_port_mode == 4'h7);
  wire      slv = ten || (i_port_mode == 4'h6);
  wire [7:0] msk = ten ? {2'b00, f[4:1], f[0], f[0]} : {2'b00, f, 1'b1};
  wire [7:0] dif = (i_i2c_addr_byte[7:0] ^ i_own_address_or_reload[7:0]) & ~msk;
  wire      hit = (ten ? i_i2c_ten_hi_ok : 1'b1) & (dif == 8'h00);
  // scl half period in clocks: twice reload plus two
  wire [9:0] half = {2'h0, i_own_address_or_reload[6:0], 1'b0} + 10'h002;
  wire      tgl = (o_scl != scl_r);
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_r <= 1'b1;
      arm_r <= 1'b0;
      hit_r <= 1'b0;
      cnt_r <= 10'h000;
    end else begin
      scl_r <= o_scl;
      arm_r <= o_bit_clock_run & ~i_sleep & (arm_r | tgl);
      hit_r <= hit;
      cnt_r <= tgl ? 10'h001 : cnt_r + 10'h001;
    end
  end
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_arst_n);
  a_flag_sticky: assert property (o_port_irq_flag && !i_irq_clear |=> o_port_irq_flag)
    else $error("irq flag lost");
  a_ack_flag: assert property (o_addr_ack |-> o_port_irq_flag)
    else $error("ack without flag");
  a_addr_match: assert property (i_i2c_addr_valid && slv |=> o_addr_ack == hit_r)
    else $error("address ack wrong");
  a_sdo_float: assert property ($rose(i_ss_n) && i_port_mode == 4'h4 |-> ##[0:6] !o_sdo_oe)
    else $error("sdo still driven");
  a_done_stop: assert property (i_op_done && !i_buf_write |=> !o_bit_clock_run)
    else $error("bit clock still runs");
  a_scl_hold: assert property (!o_bit_clock_run && !i_buf_write |=> $stable(o_scl))
    else $error("scl moved while stopped");
  a_scl_period: assert property (tgl && arm_r && o_bit_clock_run |-> cnt_r == half)
    else $error("scl half period wrong");
  a_master_go: assert property (i_buf_write && i_port_mode == 4'h8 |=> o_bit_clock_run)
    else $error("baud counter not started");
  c_ack: cover property (o_addr_ack);
  c_float: cover property ($fell(o_sdo_oe) && i_ss_n);
  c_period: cover property (tgl && arm_r);
endmodule
bind ssp_port ssp_port_checker #(.NBITS(NBITS)) ssp_port_checker_i (.*);

// file: ssp_spi_master.sv
// spi master model driving the port's serial pins
`timescale 1ns/1ns
module ssp_spi_master (
  output reg  o_sck,
  output reg  o_sdi,
  output reg  o_ss_n,
  input  wire i_sdo,
  input  wire i_sdo_oe
);
  // released data line shows a changing pattern
  reg  flip = 1'b0;
  wire line = i_sdo_oe ? i_sdo : flip;
  initial begin
    o_sck = 1'b0;
    o_sdi = 1'b1;
    o_ss_n = 1'b1;
  end
  // leading edge sampling, no edge select
  task xfer(input [7:0] tx, input integer nb, output [7:0] rx);
    integer k;
    begin
      o_ss_n = 1'b0;
      #400;
      for (k = 7; k > 7 - nb; k = k - 1) begin
        o_sdi = tx[k];
        #200;
        o_sck = 1'b1;
        #190;
        rx = {rx[6:0], line};
        #10;
        o_sck = 1'b0;
        flip = ~flip;
      end
      #400;
      o_ss_n = 1'b1;
      o_sdi = ~o_sdi;
    end
  endtask
endmodule

// file: ssp_port_tb_top.sv
// testbench for the synchronous serial port block
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin \
  checks_done = checks_done + 1; \
  if ((got) !== (ex)) begin \
    mismatches = mismatches + 1; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
  end \
end
module ssp_port_tb_top;
  reg i_clock = 1'b0, i_arst_n = 1'b0, i_port_enable_bit = 1'b0, i_clock_polarity_sel = 1'b0;
  reg i_clock_edge_sel = 1'b0, i_sdo_is_input = 1'b0, i_sleep = 1'b0, i_buf_write = 1'b0;
  reg i_i2c_addr_valid = 1'b0, i_i2c_ten_hi_ok = 1'b0, i_op_done = 1'b0, i_irq_clear = 1'b0;
  reg [3:0] i_port_mode = 4'h0;
  reg [4:0] i_address_mask_field = 5'h00;
  reg [7:0] i_own_address_or_reload = 8'h00, i_buf_wdata = 8'h00, i_i2c_addr_byte = 8'h00, rx;
  wire i_sck, i_sdi, i_ss_n, o_port_irq_flag, o_wake, o_sdo, o_sdo_oe, o_addr_ack, o_scl;
  wire o_bit_clock_run;
  wire [7:0] o_shift_data_buffer;
  reg s, wake_seen = 1'b0, oe_seen = 1'b0;
  integer mismatches = 0, checks_done = 0, a, t, n;
  ssp_port #(.NBITS(8)) ssp_port_i (.*);
  ssp_spi_master ssp_spi_master_i (.o_sck(i_sck), .o_sdi(i_sdi), .o_ss_n(i_ss_n),
    .i_sdo(o_sdo), .i_sdo_oe(o_sdo_oe));
  always #25 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    if (o_wake) wake_seen <= 1'b1;
    if (o_sdo_oe && i_sdo_is_input) oe_seen <= 1'b1;
  end
  // ****************
  // access tasks
  // ****************
  task step(input integer k);
    begin
      repeat (k) @(posedge i_clock);
      #5;
    end
  endtask
  task pulse_clear;
    begin
      i_irq_clear = 1'b1;
      step(1);
      i_irq_clear = 1'b0;
    end
  endtask
  task buf_wr(input [7:0] d);
    begin
      i_buf_wdata = d;
      i_buf_write = 1'b1;
      step(1);
      i_buf_write = 1'b0;
    end
  endtask
  task spi(input [7:0] tx, input integer nb);
    begin
      ssp_spi_master_i.xfer(tx, nb, rx);
      step(6);
    end
  endtask
  task addr(input [7:0] ad, input e);
    begin
      i_i2c_addr_byte = ad;
      i_i2c_addr_valid = 1'b1;
      step(1);
      i_i2c_addr_valid = 1'b0;
      `CHK("addr_ack", e, o_addr_ack)
      if (e) `CHK("addr_byte", ad, o_shift_data_buffer)
      pulse_clear;
    end
  endtask
  task meas(output integer k);
    begin
      s = o_scl;
      k = 0;
      while (o_scl === s && k < 600) begin
        step(1);
        k = k + 1;
      end
    end
  endtask
  function hit(input [7:0] ad, input [7:0] o, input [4:0] f, input ten, input h);
    reg [7:0] m;
    begin
      m = ten ? {2'b00, f[4:1], f[0], f[0]} : {2'b00, f, 1'b1};
      hit = (ten ? h : 1'b1) & (((ad ^ o) & ~m) == 8'h00);
    end
  endfunction
  task final_report;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    #2000000;
    mismatches = mismatches + 1;
    final_report;
  end
  initial begin
    step(8);
    i_arst_n = 1'b1;
    `CHK("scl_idle", 1'b1, o_scl)
    i_port_enable_bit = 1'b1;
    i_port_mode = 4'h4;
    step(4);
    buf_wr(8'ha5);
    spi(8'h3c, 8);
    `CHK("spi_out", 8'ha5, rx)
    `CHK("spi_in", 8'h3c, o_shift_data_buffer)
    `CHK("spi_flag", 1'b1, o_port_irq_flag)
    buf_wr(8'hc3);
    spi(8'h00, 3);
    `CHK("sdo_float", 1'b0, o_sdo_oe)
    spi(8'h81, 8);
    `CHK("count_reset", 8'h81, o_shift_data_buffer)
    pulse_clear;
    i_sleep = 1'b1;
    spi(8'h5a, 8);
    i_sleep = 1'b0;
    `CHK("wake", 1'b1, wake_seen)
    `CHK("sleep_byte", 8'h5a, o_shift_data_buffer)
    i_sdo_is_input = 1'b1;
    step(4);
    spi(8'h66, 8);
    `CHK("listen_quiet", 1'b0, oe_seen)
    i_sdo_is_input = 1'b0;
    pulse_clear;
    i_own_address_or_reload = 8'ha0;
    for (t = 0; t < 3; t = t + 1) begin
      i_port_mode = (t == 0) ? 4'h6 : 4'h7;
      i_address_mask_field = (t == 1) ? 5'h11 : 5'h07;
      i_i2c_ten_hi_ok = (t != 2);
      step(1);
      for (a = 0; a < 256; a = a + 1)
        addr(a[7:0], hit(a[7:0], 8'ha0, i_address_mask_field, t != 0, t != 2));
    end
    i_port_mode = 4'h8;
    i_own_address_or_reload = 8'h83; // reload never zero
    step(2);
    buf_wr(8'h00);
    `CHK("master_run", 1'b1, o_bit_clock_run)
    meas(n);
    meas(n);
    `CHK("scl_half", 8, n)
    i_sleep = 1'b1;
    step(2);
    s = o_scl;
    step(40);
    `CHK("sleep_scl", s, o_scl)
    i_sleep = 1'b0;
    meas(n);
    meas(n);
    `CHK("scl_resume", 8, n)
    i_op_done = 1'b1;
    step(1);
    i_op_done = 1'b0;
    s = o_scl;
    step(40);
    `CHK("run_stop", 1'b0, o_bit_clock_run)
    `CHK("scl_hold", s, o_scl)
    final_report;
  end
endmodule
